// ---- src/bce_core.sv ----
`timescale 1ns/1ps
// Fetch and register side: holds pc, link register, security state
module bce_core (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // User request
  input  wire logic              issue_i,
  input  wire bce_pkg::bce_op_t  op_i,
  input  wire logic [3:0]        cond_i,
  input  wire logic [31:0]       offset_i,
  input  wire logic [3:0]        reg_num_i,
  input  wire logic [31:0]       reg_val_i,
  input  wire logic [3:0]        nzcv_i,
  // User status
  output logic                   busy_o,
  output logic [31:0]            pc_o,
  output logic [31:0]            link_o,
  output logic                   nonsecure_o,
  output logic                   thumb_o,
  output logic                   fault_o,
  output logic [31:0]            stack_ret_o,
  // Executor side
  bce_if.core                    bus
);
  typedef struct packed {
    logic        busy;
    logic [31:0] pc;
    logic [31:0] link;
    logic        ns;
    logic        thumb;
    logic        fault;
    logic [31:0] stack_ret;
  } bce_core_st_t;

  bce_core_st_t st_reg;
  bce_core_st_t st_next;

  // One request at a time; next may issue the cycle after done
  always_comb begin
    st_next = st_reg;
    if (issue_i && !st_reg.busy) begin
      st_next.busy = 1'b1;
    end
    if (bus.done) begin
      st_next.busy  = 1'b0;
      st_next.fault = bus.fault | bus.bad_form;
      st_next.thumb = bus.thumb;
      st_next.pc    = bus.redirect ? bus.target : st_reg.pc + bce_pkg::BCE_INSTR_SIZE;
      if (bus.link_we) begin
        st_next.link = bus.link_val;
      end
      if (bus.push) begin
        st_next.stack_ret = bus.push_ret;
      end
      if (bus.enter_ns) begin
        st_next.ns = 1'b1;
      end
      if (bus.do_return) begin
        st_next.pc = st_reg.stack_ret & ~32'h0000_0001;
        st_next.ns = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= '{busy: 1'b0, pc: bce_pkg::BCE_RESET_PC, link: 32'h0000_0000,
                  ns: 1'b0, thumb: 1'b1, fault: 1'b0, stack_ret: 32'h0000_0000};
    end else begin
      st_reg <= st_next;
    end
  end

  // Request drives combinationally into the executor
  assign bus.req       = issue_i && !st_reg.busy;
  assign bus.op        = op_i;
  assign bus.cond      = cond_i;
  assign bus.pc        = st_reg.pc;
  assign bus.offset    = offset_i;
  assign bus.reg_num   = reg_num_i;
  assign bus.reg_val   = reg_val_i;
  assign bus.nonsecure = st_reg.ns;
  assign bus.nzcv      = nzcv_i;
  assign busy_o        = st_reg.busy;
  assign pc_o          = st_reg.pc;
  assign link_o        = st_reg.link;
  assign nonsecure_o   = st_reg.ns;
  assign thumb_o       = st_reg.thumb;
  assign fault_o       = st_reg.fault;
  assign stack_ret_o   = st_reg.stack_ret;
endmodule // bce_core

// ---- src/bce_exec.sv ----
`timescale 1ns/1ps
// Branch executor: one request in, one registered result out
module bce_exec (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Core side
  bce_if.exec       bus
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic        done;
    logic        redirect;
    logic [31:0] target;
    logic        thumb;
    logic        link_we;
    logic [31:0] link_val;
    logic        fault;
    logic        enter_ns;
    logic        push;
    logic [31:0] push_ret;
    logic        do_return;
    logic        bad_form;
  } bce_exec_st_t;

  bce_exec_st_t st_reg;
  bce_exec_st_t st_next;
  logic         in_range;
  logic         is_marker;
  logic         low_reg;
  logic         bad_reg;
  logic [31:0]  next_pc;
  logic [31:0]  rel_tgt;
  logic [31:0]  reg_tgt;

  bce_range_chk bce_range_chk_inst (
    .op_i       (bus.op),
    .offset_i   (bus.offset),
    .in_range_o (in_range)
  );

  // ****************************************************************
  // Decode and execute
  // ****************************************************************
  // Flags are never an output here, so no branch form can alter them [RULE_08]
  always_comb begin
    next_pc   = bus.pc + bce_pkg::BCE_INSTR_SIZE;
    rel_tgt   = bus.pc + bus.offset;                               // [RULE_01]
    reg_tgt   = {bus.reg_val[31:1], 1'b0};                         // [RULE_05]
    is_marker = (bus.reg_val == bce_pkg::BCE_FNC_MARKER) ||
                (bus.reg_val[31:24] == bce_pkg::BCE_EXC_MARKER[31:24]);
    low_reg   = bus.reg_num <= bce_pkg::BCE_LOW_REG_LAST;          // [RULE_14]
    bad_reg   = (bus.reg_num == bce_pkg::BCE_SP_NUM) ||
                (bus.reg_num == bce_pkg::BCE_PC_NUM);              // [RULE_17] [RULE_18]
    st_next   = '0;
    if (bus.req) begin
      st_next.done     = 1'b1;
      st_next.thumb    = 1'b1;
      st_next.bad_form = ~in_range;
      case (bus.op)
        bce_pkg::BCE_OP_JUMP,
        bce_pkg::BCE_OP_JUMP_SH: begin
          st_next.redirect = 1'b1;                                 // [RULE_07]
          st_next.target   = rel_tgt;
        end
        bce_pkg::BCE_OP_JUMP_CND: begin
          st_next.redirect = bce_pkg::bce_cond_holds(bus.cond, bus.nzcv); // [RULE_19]
          st_next.target   = rel_tgt;
        end
        bce_pkg::BCE_OP_CALL: begin
          st_next.redirect = 1'b1;
          st_next.target   = rel_tgt;
          st_next.link_we  = 1'b1;                                 // [RULE_02]
          st_next.link_val = {next_pc[31:1], 1'b1};                // [RULE_03]
        end
        bce_pkg::BCE_OP_REG_JUMP,
        bce_pkg::BCE_OP_REG_CALL: begin
          st_next.bad_form = bad_reg;
          if (is_marker && bus.op == bce_pkg::BCE_OP_REG_JUMP) begin
            st_next.do_return = 1'b1;                              // [RULE_09]
          end else if (!bus.reg_val[0]) begin
            st_next.fault = 1'b1;                                  // [RULE_04]
            st_next.thumb = 1'b0;                                  // [RULE_05]
          end else begin
            st_next.redirect = 1'b1;
            st_next.target   = reg_tgt;                            // [RULE_01]
            if (bus.op == bce_pkg::BCE_OP_REG_CALL) begin
              st_next.link_we  = 1'b1;                             // [RULE_02]
              st_next.link_val = {next_pc[31:1], 1'b1};            // [RULE_03]
            end
          end
        end
        bce_pkg::BCE_OP_NS_JUMP,
        bce_pkg::BCE_OP_NS_CALL: begin
          st_next.bad_form = bad_reg;
          if (bus.nonsecure) begin
            st_next.fault = 1'b1;                                  // [RULE_12]
          end else begin
            st_next.redirect = 1'b1;
            st_next.target   = reg_tgt;
            st_next.enter_ns = ~bus.reg_val[0];                    // [RULE_10]
            if (bus.op == bce_pkg::BCE_OP_NS_CALL) begin
              st_next.link_we = 1'b1;
              if (!bus.reg_val[0]) begin
                st_next.push     = 1'b1;                           // [RULE_11]
                st_next.push_ret = {next_pc[31:1], 1'b1};
                st_next.link_val = bce_pkg::BCE_FNC_MARKER;        // [RULE_11]
              end else begin
                st_next.link_val = {next_pc[31:1], 1'b1};          // [RULE_03]
              end
            end
          end
        end
        bce_pkg::BCE_OP_CMP_Z,
        bce_pkg::BCE_OP_CMP_NZ: begin
          st_next.bad_form = ~in_range | ~low_reg;                 // [RULE_15]
          st_next.redirect = (bus.reg_val == 32'h0000_0000) ==
                             (bus.op == bce_pkg::BCE_OP_CMP_Z);    // [RULE_13]
          st_next.target   = rel_tgt;
        end
        default: begin
          st_next.done = 1'b0;
        end
      endcase
      if (st_next.bad_form) begin
        st_next.redirect = 1'b0;
        st_next.link_we  = 1'b0;
        st_next.push     = 1'b0;
        st_next.enter_ns = 1'b0;
      end
    end
  end

  // Result register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.done      = st_reg.done;
  assign bus.redirect  = st_reg.redirect;
  assign bus.target    = st_reg.target;
  assign bus.thumb     = st_reg.thumb;
  assign bus.link_we   = st_reg.link_we;
  assign bus.link_val  = st_reg.link_val;
  assign bus.fault     = st_reg.fault;
  assign bus.enter_ns  = st_reg.enter_ns;
  assign bus.push      = st_reg.push;
  assign bus.push_ret  = st_reg.push_ret;
  assign bus.do_return = st_reg.do_return;
  assign bus.bad_form  = st_reg.bad_form;
endmodule // bce_exec

// ---- src/bce_if.sv ----
`timescale 1ns/1ps
// Link between fetch/register side and branch executor
interface bce_if;
  logic              req;
  bce_pkg::bce_op_t  op;
  logic [3:0]        cond;
  logic [31:0]       pc;
  logic [31:0]       offset;
  logic [3:0]        reg_num;
  logic [31:0]       reg_val;
  logic              nonsecure;
  logic [3:0]        nzcv;
  logic              done;
  logic              redirect;
  logic [31:0]       target;
  logic              thumb;
  logic              link_we;
  logic [31:0]       link_val;
  logic              fault;
  logic              enter_ns;
  logic              push;
  logic [31:0]       push_ret;
  logic              do_return;
  logic              bad_form;
  modport exec (
    input  req, op, cond, pc, offset, reg_num, reg_val, nonsecure, nzcv,
    output done, redirect, target, thumb, link_we, link_val, fault,
    output enter_ns, push, push_ret, do_return, bad_form
  );
  modport core (
    output req, op, cond, pc, offset, reg_num, reg_val, nonsecure, nzcv,
    input  done, redirect, target, thumb, link_we, link_val, fault,
    input  enter_ns, push, push_ret, do_return, bad_form
  );
endinterface

// ---- src/bce_pkg.sv ----
// Behaviour
// [RULE_01] Jumps redirect to label or target register
// [RULE_02] Calls write next address to link register
// [RULE_03] Stored link value has bit 0 set
// [RULE_04] Register jump with bit 0 clear faults
// [RULE_05] Target bit 0 sets thumb flag, cleared
// [RULE_06] Relative spans: 2KB, 256/254 bytes, 16MB
// [RULE_07] Only conditional jump carries a condition
// [RULE_08] Jumps and calls leave flags untouched
// [RULE_09] Return marker in target triggers return
// [RULE_10] Target bit 0 clear enters nonsecure state
// [RULE_11] Nonsecure call pushes state, loads marker
// [RULE_12] Nonsecure jump from nonsecure state faults
// [RULE_13] Compare jumps test zero, keep flags
// [RULE_14] Compare operand is register 0 to 7
// [RULE_15] Compare jump target 4 to 130 forward
// [RULE_16] No compare jumps in conditional group
// [RULE_17] No stack pointer or counter as target
// [RULE_18] Same for nonsecure jump and call
// [RULE_19] Conditional jump uses standard condition codes
package bce_pkg;

  // ****************************************************************
  // Operation codes passed from fetch to the executor
  // ****************************************************************
  typedef enum logic [3:0] {
    BCE_OP_NONE     = 4'h0,
    BCE_OP_JUMP     = 4'h1,
    BCE_OP_JUMP_SH  = 4'h2,
    BCE_OP_JUMP_CND = 4'h3,
    BCE_OP_CALL     = 4'h4,
    BCE_OP_REG_JUMP = 4'h5,
    BCE_OP_REG_CALL = 4'h6,
    BCE_OP_NS_JUMP  = 4'h7,
    BCE_OP_NS_CALL  = 4'h8,
    BCE_OP_CMP_Z    = 4'h9,
    BCE_OP_CMP_NZ   = 4'ha
  } bce_op_t;

  // ****************************************************************
  // Offset spans in bytes and register numbers
  // ****************************************************************
  localparam logic signed [31:0] BCE_JUMP_MIN     = -32'sh0000_0800;
  localparam logic signed [31:0] BCE_JUMP_MAX     = 32'sh0000_0800;
  localparam logic signed [31:0] BCE_JUMP_SH_MIN  = -32'sh0000_0100;
  localparam logic signed [31:0] BCE_JUMP_SH_MAX  = 32'sh0000_00fe;
  localparam logic signed [31:0] BCE_CALL_MIN     = -32'sh0100_0000;
  localparam logic signed [31:0] BCE_CALL_MAX     = 32'sh0100_0000;
  localparam logic signed [31:0] BCE_CMP_MIN      = 32'sh0000_0004;
  localparam logic signed [31:0] BCE_CMP_MAX      = 32'sh0000_0082;
  localparam logic [3:0]         BCE_LINK_REG_NUM = 4'he;
  localparam logic [3:0]         BCE_SP_NUM       = 4'hd;
  localparam logic [3:0]         BCE_PC_NUM       = 4'hf;
  localparam logic [3:0]         BCE_LOW_REG_LAST = 4'h7;
  localparam logic [31:0]        BCE_INSTR_SIZE   = 32'h0000_0004;
  localparam logic [31:0]        BCE_FNC_MARKER   = 32'hffff_fffe;
  localparam logic [31:0]        BCE_EXC_MARKER   = 32'hff00_0000;
  localparam logic [31:0]        BCE_RESET_PC     = 32'h0000_0000;

  // ****************************************************************
  // Condition evaluation, flags ordered n z c v
  // ****************************************************************
  function automatic logic bce_cond_holds(input logic [3:0] cond,
                                          input logic [3:0] nzcv);
    logic n;
    logic z;
    logic c;
    logic v;
    logic r;
    n = nzcv[3];
    z = nzcv[2];
    c = nzcv[1];
    v = nzcv[0];
    case (cond[3:1])
      3'h0:    r = z;
      3'h1:    r = c;
      3'h2:    r = n;
      3'h3:    r = v;
      3'h4:    r = c & ~z;
      3'h5:    r = (n == v);
      3'h6:    r = (n == v) & ~z;
      default: r = 1'b1;
    endcase
    // Odd codes invert, except the always code 4'he/4'hf
    if (cond[0] && (cond[3:1] != 3'h7)) begin
      r = ~r;
    end
    return r;
  endfunction

endpackage

// ---- src/bce_range_chk.sv ----
`timescale 1ns/1ps
// Span check for relative offsets
module bce_range_chk (
  // Operands
  input  wire bce_pkg::bce_op_t op_i,
  input  wire logic [31:0]      offset_i,
  // Result
  output logic                  in_range_o
);
  logic signed [31:0] off;
  // Pick the span of each relative form
  always_comb begin
    off = signed'(offset_i);
    case (op_i)
      bce_pkg::BCE_OP_JUMP:     in_range_o = (off >= bce_pkg::BCE_JUMP_MIN) &&
                                             (off <= bce_pkg::BCE_JUMP_MAX); // [RULE_06]
      bce_pkg::BCE_OP_JUMP_SH,
      bce_pkg::BCE_OP_JUMP_CND: in_range_o = (off >= bce_pkg::BCE_JUMP_SH_MIN) &&
                                             (off <= bce_pkg::BCE_JUMP_SH_MAX); // [RULE_06]
      bce_pkg::BCE_OP_CALL:     in_range_o = (off >= bce_pkg::BCE_CALL_MIN) &&
                                             (off <= bce_pkg::BCE_CALL_MAX); // [RULE_06]
      bce_pkg::BCE_OP_CMP_Z,
      bce_pkg::BCE_OP_CMP_NZ:   in_range_o = (off >= bce_pkg::BCE_CMP_MIN) &&
                                             (off <= bce_pkg::BCE_CMP_MAX); // [RULE_15]
      default:                  in_range_o = 1'b1;
    endcase
  end
endmodule // bce_range_chk

// ---- tb/bce_bench.sv ----
`timescale 1ns/1ps
module branch_control_execute_bench;
  logic             core_clk_i, rst_i, issue_i, busy_o, nonsecure_o, thumb_o, fault_o;
  bce_pkg::bce_op_t op_i;
  logic [3:0]       cond_i, reg_num_i, nzcv_i;
  logic [31:0]      offset_i, reg_val_i, pc_o, link_o, stack_ret_o, exp_pc;
  int               failures, samples_checked;

  bce_if bce_if_inst ();
  bce_exec bce_exec_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus(bce_if_inst.exec));
  bce_core bce_core_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .issue_i(issue_i),
    .op_i(op_i), .cond_i(cond_i), .offset_i(offset_i), .reg_num_i(reg_num_i),
    .reg_val_i(reg_val_i), .nzcv_i(nzcv_i), .busy_o(busy_o), .pc_o(pc_o), .link_o(link_o),
    .nonsecure_o(nonsecure_o), .thumb_o(thumb_o), .fault_o(fault_o),
    .stack_ret_o(stack_ret_o), .bus(bce_if_inst.core));
  bce_chk bce_chk_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .req(bce_if_inst.req),
    .op(bce_if_inst.op), .pc(bce_if_inst.pc), .offset(bce_if_inst.offset),
    .reg_num(bce_if_inst.reg_num), .reg_val(bce_if_inst.reg_val),
    .nonsecure(bce_if_inst.nonsecure), .done(bce_if_inst.done),
    .redirect(bce_if_inst.redirect), .target(bce_if_inst.target), .thumb(bce_if_inst.thumb),
    .link_we(bce_if_inst.link_we), .link_val(bce_if_inst.link_val), .fault(bce_if_inst.fault),
    .enter_ns(bce_if_inst.enter_ns), .push(bce_if_inst.push), .bad_form(bce_if_inst.bad_form));

  // 100 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One instruction: issue at a falling edge, wait for busy to drop, compare pc and fault
  task automatic run(input bce_pkg::bce_op_t op, input logic [3:0] num, input logic [31:0] val,
                     input logic [31:0] off, input logic [31:0] npc, input logic flt);
    int i;
    op_i = op;
    reg_num_i = num;
    reg_val_i = val;
    offset_i = off;
    issue_i = 1'b1;
    @(negedge core_clk_i);
    issue_i = 1'b0;
    @(negedge core_clk_i);
    for (i = 0; i < 8 && busy_o !== 1'b0; i++) @(negedge core_clk_i);
    check({31'h0, busy_o}, 32'h0);
    check(pc_o, npc);
    check({31'h0, fault_o}, {31'h0, flt});
    exp_pc = npc;
  endtask

  // Reference condition decision, flags n z c v in bits 3..0
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & ~f[2];
      3'h5: r = f[3] == f[0];
      3'h6: r = (f[3] == f[0]) & ~f[2];
      default: r = 1'b1;
    endcase
    return (c[0] && c != 4'hf) ? ~r : r;
  endfunction

  // Watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge core_clk_i);
    failures++;
    print_verdict();
  end

  initial begin
    logic [31:0] t;
    int k;
    rst_i = 1'b1;
    issue_i = 1'b0;
    op_i = bce_pkg::BCE_OP_JUMP;
    {cond_i, reg_num_i, nzcv_i, offset_i, reg_val_i, exp_pc} = '0;
    failures = 0;
    samples_checked = 0;
    repeat (16) @(negedge core_clk_i);
    rst_i = 1'b0;
    check(pc_o, 32'h0);
    check({30'h0, thumb_o, nonsecure_o}, 32'h2);
    run(bce_pkg::BCE_OP_JUMP, 4'h0, 32'h0, 32'h800, 32'h800, 1'b0);
    run(bce_pkg::BCE_OP_JUMP, 4'h0, 32'h0, 32'h804, exp_pc + 32'h4, 1'b1);
    run(bce_pkg::BCE_OP_JUMP_SH, 4'h0, 32'h0, 32'hffff_ff00, exp_pc - 32'h100, 1'b0);
    t = exp_pc;
    run(bce_pkg::BCE_OP_CALL, 4'h0, 32'h0, 32'h100, exp_pc + 32'h100, 1'b0);
    check(link_o, (t + 32'h4) | 32'h1);
    t = exp_pc;
    run(bce_pkg::BCE_OP_REG_CALL, 4'h1, 32'h2001, 32'h0, 32'h2000, 1'b0);
    check(link_o, (t + 32'h4) | 32'h1);
    check({31'h0, thumb_o}, 32'h1);
    run(bce_pkg::BCE_OP_REG_JUMP, 4'h2, 32'h3000, 32'h0, exp_pc + 32'h4, 1'b1);
    check({31'h0, thumb_o}, 32'h0);
    run(bce_pkg::BCE_OP_REG_JUMP, 4'hd, 32'h3001, 32'h0, exp_pc + 32'h4, 1'b1);
    $display("test direct and register jumps done");
    run(bce_pkg::BCE_OP_JUMP, 4'h0, 32'h0, 32'h10, exp_pc + 32'h10, 1'b0);
    for (k = 0; k < 64; k++) begin
      nzcv_i = 4'(5 * (k / 16));
      cond_i = 4'(k);
      run(bce_pkg::BCE_OP_JUMP_CND, 4'h0, 32'h0, 32'h10,
          exp_pc + (cond_ok(cond_i, nzcv_i) ? 32'h10 : 32'h4), 1'b0);
    end
    $display("test condition codes done");
    for (k = 0; k < 4; k++) begin
      run(k[0] ? bce_pkg::BCE_OP_CMP_NZ : bce_pkg::BCE_OP_CMP_Z, 4'h7, k[1] ? 32'h5 : 32'h0,
          32'h82, exp_pc + ((k[0] == k[1]) ? 32'h82 : 32'h4), 1'b0);
    end
    run(bce_pkg::BCE_OP_CMP_Z, 4'h3, 32'h0, 32'h84, exp_pc + 32'h4, 1'b1);
    run(bce_pkg::BCE_OP_CMP_NZ, 4'h3, 32'h1, 32'h2, exp_pc + 32'h4, 1'b1);
    run(bce_pkg::BCE_OP_CMP_Z, 4'h8, 32'h0, 32'h10, exp_pc + 32'h4, 1'b1);
    $display("test compare jumps done");
    t = exp_pc;
    run(bce_pkg::BCE_OP_NS_CALL, 4'h1, 32'h4000, 32'h0, 32'h4000, 1'b0);
    check(link_o, bce_pkg::BCE_FNC_MARKER);
    check(stack_ret_o, (t + 32'h4) | 32'h1);
    check({31'h0, nonsecure_o}, 32'h1);
    run(bce_pkg::BCE_OP_NS_JUMP, 4'h1, 32'h5000, 32'h0, exp_pc + 32'h4, 1'b1);
    check({31'h0, nonsecure_o}, 32'h1);
    run(bce_pkg::BCE_OP_REG_JUMP, 4'he, 32'hffff_fffe, 32'h0, t + 32'h4, 1'b0);
    check({31'h0, nonsecure_o}, 32'h0);
    run(bce_pkg::BCE_OP_NS_JUMP, 4'hf, 32'h7000, 32'h0, exp_pc + 32'h4, 1'b1);
    check({31'h0, nonsecure_o}, 32'h0);
    t = exp_pc;
    run(bce_pkg::BCE_OP_NS_CALL, 4'h1, 32'h6001, 32'h0, 32'h6000, 1'b0);
    check(link_o, (t + 32'h4) | 32'h1);
    check({31'h0, nonsecure_o}, 32'h0);
    $display("test nonsecure calls done");
    print_verdict();
  end
endmodule // branch_control_execute_bench

// ---- tb/bce_sva.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Checker on the link between core side and executor
// ****************************************************************
module bce_chk (
  // Clock and reset
  input wire logic             core_clk_i,
  input wire logic             rst_i,
  // Core to executor
  input wire logic             req,
  input wire bce_pkg::bce_op_t op,
  input wire logic [31:0]      pc,
  input wire logic [31:0]      offset,
  input wire logic [3:0]       reg_num,
  input wire logic [31:0]      reg_val,
  input wire logic             nonsecure,
  // Executor to core
  input wire logic             done,
  input wire logic             redirect,
  input wire logic [31:0]      target,
  input wire logic             thumb,
  input wire logic             link_we,
  input wire logic [31:0]      link_val,
  input wire logic             fault,
  input wire logic             enter_ns,
  input wire logic             push,
  input wire logic             bad_form
);
  logic             req_q;
  bce_pkg::bce_op_t op_q;
  logic [31:0]      pc_q;
  logic [31:0]      val_q;
  logic [31:0]      off_q;
  logic [3:0]       num_q;
  logic             ns_q;
  logic             reg_form;
  logic             ns_op;
  logic             cmp_op;
  logic             cmp_in;

  // Request copies, since inputs are only valid in the issue cycle
  always_ff @(posedge core_clk_i) begin
    req_q <= req && !rst_i;
    op_q  <= op;
    pc_q  <= pc;
    val_q <= reg_val;
    off_q <= offset;
    num_q <= reg_num;
    ns_q  <= nonsecure;
  end

  // Classify the request that the current answer belongs to
  assign reg_form = req_q && (op_q == bce_pkg::BCE_OP_REG_JUMP || op_q == bce_pkg::BCE_OP_REG_CALL)
                    && num_q < 4'hd && val_q[31:24] != 8'hff;
  assign ns_op  = op_q == bce_pkg::BCE_OP_NS_JUMP || op_q == bce_pkg::BCE_OP_NS_CALL;
  assign cmp_op = op_q == bce_pkg::BCE_OP_CMP_Z || op_q == bce_pkg::BCE_OP_CMP_NZ;
  assign cmp_in = $signed(off_q) >= 4 && $signed(off_q) <= 130;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  done_after_req_a: assert property (req |=> done) else $error("no answer after request");
  done_pulse_a: assert property (done |=> !done) else $error("answer longer than one cycle");
  quiet_idle_a: assert property (!done |-> !redirect && !link_we && !fault && !push)
    else $error("result outside answer cycle");
  link_odd_a: assert property (link_we && !push |-> link_val[0])
    else $error("link value bit 0 clear");
  call_link_a: assert property (done && link_we && op_q == bce_pkg::BCE_OP_CALL
    |-> link_val == ((pc_q + bce_pkg::BCE_INSTR_SIZE) | 32'h1)) else $error("bad link value");
  reg_fault_a: assert property (reg_form && !val_q[0] |-> fault && !redirect)
    else $error("even target did not fault");
  thumb_target_a: assert property (reg_form && val_q[0]
    |-> redirect && thumb && target == {val_q[31:1], 1'b0}) else $error("bad register target");
  ns_enter_a: assert property (req_q && ns_op && !ns_q && !val_q[0] && num_q < 4'hd
    |-> enter_ns) else $error("no switch to nonsecure");
  ns_undef_a: assert property (req_q && ns_op && ns_q |-> fault && !enter_ns)
    else $error("nonsecure op from nonsecure state");
  ns_push_a: assert property (push |-> enter_ns && link_val == bce_pkg::BCE_FNC_MARKER)
    else $error("push without marker");
  cmp_span_a: assert property (req_q && cmp_op && !cmp_in |-> bad_form && !redirect)
    else $error("compare span not refused");
  cmp_zero_a: assert property (req_q && cmp_op && cmp_in && num_q <= 4'h7
    |-> redirect == ((val_q == 32'h0) == (op_q == bce_pkg::BCE_OP_CMP_Z)))
    else $error("compare jump decision wrong");

  cover property (push);
  cover property (done && fault);
  cover property (done && redirect && thumb);
endmodule // bce_chk
